// *** odc_angle_cmp.sv ***
// Back/front and Z-tilt lockout candidate comparators
`timescale 1ns/100ps
module odc_angle_cmp (
  // Clock and reset, used by checks only
  input wire logic ref_clk,
  input wire logic reset,
  // Settings
  input wire logic [1:0] bkfr_code,
  input wire logic [2:0] zlock_code,
  // Measured angles and present state
  input wire logic [8:0] z_angle_deg,
  input wire logic [9:0] z_tilt_deci,
  input wire logic bafro_now,
  // Candidates
  output logic bafro_cand,
  output logic lockout_cand
);
  import odc_pkg::*;

  logic [8:0] shift_deg;
  logic to_back;
  logic to_front;

  // Each code step moves every trip angle out by 5 degrees, widening the dead band by 10
  assign shift_deg = 9'(bkfr_code * BF_STEP_DEG);
  assign to_back = (z_angle_deg > BF_TO_BACK_LO + shift_deg) &&
    (z_angle_deg < BF_TO_BACK_HI - shift_deg); // RQ12
  assign to_front = (z_angle_deg < BF_TO_FRONT_LO - shift_deg) ||
    (z_angle_deg > BF_TO_FRONT_HI + shift_deg); // RQ12
  // Between the two bands the side is kept, giving hysteresis
  assign bafro_cand = bafro_now ? !to_front : to_back; // RQ11

  // Tilt below the selected angle sets the lockout candidate
  assign lockout_cand = (z_tilt_deci < ZLOCK_DECI[zlock_code]); // RQ9 RQ10

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_front_to_back;
    !bafro_now && z_angle_deg > 9'd115 && z_angle_deg < 9'd245
      |-> bafro_cand;
  endproperty
  a_front_to_back: assert property (p_front_to_back) // RQ12
    else $error("front to back missed inside band");
  property p_lock_code7;
    zlock_code == 3'h7 && z_tilt_deci < 10'd404 |-> lockout_cand;
  endproperty
  a_lock_code7: assert property (p_lock_code7) // RQ10
    else $error("lockout missed at largest code");

endmodule : odc_angle_cmp

// *** odc_orient_debounce.sv ***
// Orientation debounce counter with angle settings and registers
// Function
// [RQ1] Eight-bit read/write debounce count, reset zero
// [RQ2] Latency is count times the step
// [RQ3] Clear counters on rate or active change
// [RQ4] Hybrid operation doubles each debounce step
// [RQ5] Step is one sample period down to 50 Hz
// [RQ6] Slower rates: 20, 80 or 160 ms steps
// [RQ7] High resolution: 1.25 ms, else 2.5 ms
// [RQ8] Longest debounce is full count times step
// [RQ9] Three-bit Z-tilt lockout code, default 4
// [RQ10] Lockout codes select 13.6 to 40.4 degrees
// [RQ11] Two-bit back/front code, default 0b10
// [RQ12] Back/front trips shift 5 degrees per code
// [RQ13] Counter mode: decrement or clear, resets clear
// [RQ14] Change flag set on change, read clears
// [RQ15] State commits only when count is reached
`timescale 1ns/100ps
module odc_orient_debounce #(
  parameter int unsigned STEP_UNIT_CYCLES = odc_pkg::STEP_UNIT_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Measurements from the sample path
  input wire logic [1:0] raw_lapo,
  input wire logic [8:0] z_angle_deg,
  input wire logic [9:0] z_tilt_deci,
  // Results
  output odc_pkg::odc_orient_t orient_state,
  output logic z_tilt_locked_flag,
  output logic irq
);
  import odc_pkg::*;

  logic [7:0] debounce_count_value_reg;
  logic cntm_reg;
  logic enable_reg;
  logic [1:0] bkfr_reg;
  logic [2:0] zlock_reg;
  odc_sys_t sys_reg;
  logic [2:0] rate_prev_reg;
  logic active_prev_reg;
  logic [7:0] cnt_reg;
  odc_orient_t state_reg;
  logic first_det_reg;
  logic newlp_reg;
  logic [1:0] int_status_reg;
  logic [1:0] int_mask_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  logic rate_chg;
  logic active_chg;
  logic dbc_clear;
  logic step_tick;
  logic tick_q;
  logic diff;
  logic commit;
  logic newlp_set;
  logic [1:0] int_event;
  logic bafro_cand;
  logic lockout_cand;
  odc_orient_t cand;

  // Step timer, restarted with the debounce counter
  odc_step_timer #(
    .STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)
  ) u_step (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(dbc_clear),
    .sys(sys_reg),
    .step_units(),
    .step_tick(step_tick)
  );

  // Angle comparators feeding the candidate orientation
  odc_angle_cmp u_cmp (
    .ref_clk(ref_clk),
    .reset(reset),
    .bkfr_code(bkfr_reg),
    .zlock_code(zlock_reg),
    .z_angle_deg(z_angle_deg),
    .z_tilt_deci(z_tilt_deci),
    .bafro_now(state_reg.bafro),
    .bafro_cand(bafro_cand),
    .lockout_cand(lockout_cand)
  );

  assign cand.lockout = lockout_cand;
  assign cand.lapo = raw_lapo;
  assign cand.bafro = bafro_cand;

  // Configuration registers written by software
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      debounce_count_value_reg <= COUNT_RST; // RQ1
      cntm_reg <= CNTM_RST; // RQ13
      enable_reg <= 1'b0;
      bkfr_reg <= BKFR_RST; // RQ11
      zlock_reg <= ZLOCK_RST; // RQ9
      sys_reg <= '0;
      int_mask_reg <= INT_RST;
    end else if (reg_write) begin
      unique case (reg_addr)
        ADDR_COUNT: debounce_count_value_reg <= reg_wdata; // RQ1
        ADDR_CFG: begin
          cntm_reg <= reg_wdata[CFG_CNTM_BIT];
          enable_reg <= reg_wdata[CFG_EN_BIT];
        end
        ADDR_BFZ: begin
          bkfr_reg <= reg_wdata[BFZ_BKFR_LSB +: 2];
          zlock_reg <= reg_wdata[2:0];
        end
        ADDR_SYS: sys_reg <= reg_wdata[6:0];
        ADDR_INT_MASK: int_mask_reg <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Change detection on sample rate and standby/active
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rate_prev_reg <= 3'h0;
      active_prev_reg <= 1'b0;
    end else begin
      rate_prev_reg <= sys_reg.output_sample_rate;
      active_prev_reg <= sys_reg.active;
    end
  end

  assign rate_chg = (rate_prev_reg != sys_reg.output_sample_rate);
  assign active_chg = (active_prev_reg != sys_reg.active);
  // Standby or disable also holds the counter at zero
  assign dbc_clear = rate_chg || active_chg ||
    !sys_reg.active || !enable_reg; // RQ3

  assign tick_q = step_tick && !dbc_clear;
  assign diff = (cand != state_reg);
  // Zero count commits on the first differing sample
  assign commit = tick_q && diff &&
    (cnt_reg == debounce_count_value_reg); // RQ15 RQ2 RQ8

  // Debounce counter
  always_ff @(posedge ref_clk) begin
    if (reset || dbc_clear) begin
      cnt_reg <= 8'h00; // RQ3
    end else if (tick_q) begin
      if (commit) begin
        cnt_reg <= 8'h00; // RQ15
      end else if (diff) begin
        cnt_reg <= cnt_reg + 8'h01; // RQ2
      end else if (cntm_reg || cnt_reg == 8'h00) begin
        cnt_reg <= 8'h00; // RQ13
      end else begin
        cnt_reg <= cnt_reg - 8'h01; // RQ13
      end
    end
  end

  // Reported orientation, only on a committed transition
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= '0;
    end else if (commit) begin
      state_reg <= cand; // RQ15
    end
  end

  // First detection after waking is reported even without change
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      first_det_reg <= 1'b0;
    end else if (active_chg && sys_reg.active) begin
      first_det_reg <= 1'b1;
    end else if (tick_q) begin
      first_det_reg <= 1'b0;
    end
  end

  assign newlp_set = commit || (tick_q && first_det_reg); // RQ14

  // Change flag; a new event beats a clearing read
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      newlp_reg <= 1'b0;
    end else if (newlp_set) begin
      newlp_reg <= 1'b1; // RQ14
    end else if (reg_read && reg_addr == ADDR_STATUS) begin
      newlp_reg <= 1'b0; // RQ14
    end
  end

  assign int_event[INT_ORIENT_BIT] = newlp_set;
  assign int_event[INT_LOCK_BIT] = commit && cand.lockout &&
    !state_reg.lockout;

  // Sticky interrupt status, cleared by reading it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      int_status_reg <= INT_RST;
    end else if (reg_read && reg_addr == ADDR_INT_STATUS) begin
      int_status_reg <= int_event;
    end else begin
      int_status_reg <= int_status_reg | int_event;
    end
  end

  assign irq = |(int_status_reg & int_mask_reg);

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      ADDR_STATUS: begin
        rdata_next[ST_NEW_BIT] = newlp_reg;
        rdata_next[ST_LOCK_BIT] = state_reg.lockout;
        rdata_next[ST_LAPO_LSB +: 2] = state_reg.lapo;
        rdata_next[ST_BAFRO_BIT] = state_reg.bafro;
      end
      ADDR_CFG: begin
        rdata_next[CFG_CNTM_BIT] = cntm_reg;
        rdata_next[CFG_EN_BIT] = enable_reg;
      end
      ADDR_COUNT: rdata_next = debounce_count_value_reg;
      ADDR_BFZ: rdata_next = {bkfr_reg, 3'h0, zlock_reg};
      ADDR_SYS: rdata_next = {1'b0, sys_reg};
      ADDR_INT_STATUS: rdata_next = {6'h00, int_status_reg};
      ADDR_INT_MASK: rdata_next = {6'h00, int_mask_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (reset || !reg_read) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign orient_state = state_reg;
  assign z_tilt_locked_flag = state_reg.lockout;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_count_reset;
    disable iff (1'b0) reset |=> debounce_count_value_reg == 8'h00;
  endproperty
  a_count_reset: assert property (p_count_reset) // RQ1
    else $error("debounce count not zero after reset");
  property p_count_readback;
    reg_read && reg_addr == ADDR_COUNT && !reg_write
      |=> reg_rdata == $past(debounce_count_value_reg);
  endproperty
  a_count_readback: assert property (p_count_readback) // RQ1
    else $error("debounce count read back wrong");
  property p_clear_on_rate;
    rate_chg || active_chg |=> cnt_reg == 8'h00;
  endproperty
  a_clear_on_rate: assert property (p_clear_on_rate) // RQ3
    else $error("counter kept across rate or active change");
  property p_commit_at_count;
    state_reg != $past(state_reg) |->
      $past(tick_q) && $past(cnt_reg) == $past(debounce_count_value_reg);
  endproperty
  a_commit_at_count: assert property (p_commit_at_count) // RQ15
    else $error("orientation changed before count reached");
  property p_clear_mode;
    tick_q && !diff && cntm_reg |=> cnt_reg == 8'h00;
  endproperty
  a_clear_mode: assert property (p_clear_mode) // RQ13
    else $error("clear mode did not clear counter");
  property p_dec_mode;
    tick_q && !diff && !cntm_reg && cnt_reg != 8'h00
      |=> cnt_reg == $past(cnt_reg) - 8'h01;
  endproperty
  a_dec_mode: assert property (p_dec_mode) // RQ13
    else $error("decrement mode did not decrement");
  property p_newlp_set;
    commit |=> newlp_reg ##1 (newlp_reg || $past(reg_read));
  endproperty
  a_newlp_set: assert property (p_newlp_set) // RQ14
    else $error("change flag not set on commit");
  property p_newlp_clear;
    reg_read && reg_addr == ADDR_STATUS && !newlp_set |=> !newlp_reg;
  endproperty
  a_newlp_clear: assert property (p_newlp_clear) // RQ14
    else $error("status read did not clear change flag");
  property p_bfz_reset;
    disable iff (1'b0) reset |=> bkfr_reg == 2'h2 && zlock_reg == 3'h4;
  endproperty
  a_bfz_reset: assert property (p_bfz_reset) // RQ9 RQ11
    else $error("angle settings reset wrong");
  property p_irq_follows;
    int_event[INT_ORIENT_BIT] && int_mask_reg[INT_ORIENT_BIT] |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("unmasked event did not raise interrupt");

  c_commit: cover property (commit);
  c_zero_count_commit: cover property (
    commit && debounce_count_value_reg == 8'h00);
  c_rate_change_mid_count: cover property (rate_chg && cnt_reg != 8'h00);
  c_status_read_newlp: cover property (
    newlp_reg && reg_read && reg_addr == ADDR_STATUS);

endmodule : odc_orient_debounce

// *** odc_orient_debounce_test.sv ***
// Self-checking testbench for the orientation debounce block
`timescale 1ns/100ps
module odc_orient_debounce_test;
  import odc_pkg::*;

  // Shortened time base: one 1.25 ms unit is SU clock cycles
  localparam int SU = 4;

  // Design connections
  logic ref_clk;
  logic reset;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_rdata;
  logic [1:0] raw_lapo;
  logic [8:0] z_angle_deg;
  logic [9:0] z_tilt_deci;
  odc_orient_t orient_state;
  logic z_tilt_locked_flag;
  logic irq;

  // Bookkeeping
  int err_count;
  int n_checks;
  logic [1:0] cur;
  logic [7:0] rv;
  int n;

  // Step table: rate, mode, hybrid and expected step in units
  logic [2:0] rt [11] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h7, 3'h5, 3'h6, 3'h7,
    3'h0, 3'h4, 3'h1};
  logic [1:0] md [11] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h1, 2'h3, 2'h3, 2'h3,
    2'h2, 2'h2, 2'h0};
  logic hy [11] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
    1'b0, 1'b0, 1'b1};
  int un [11] = '{1, 4, 16, 16, 64, 64, 128, 128, 1, 2, 4};

  // Lockout thresholds in tenths of a degree, by code
  logic [9:0] th [8] = '{10'h088, 10'h0ab, 10'h0cf, 10'h0f4, 10'h119,
    10'h140, 10'h169, 10'h194};

  odc_orient_debounce #(.STEP_UNIT_CYCLES(SU)) DUT (
    .ref_clk(ref_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .raw_lapo(raw_lapo),
    .z_angle_deg(z_angle_deg),
    .z_tilt_deci(z_tilt_deci),
    .orient_state(orient_state),
    .z_tilt_locked_flag(z_tilt_locked_flag),
    .irq(irq)
  );

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] sysv(input logic [2:0] r,
      input logic [1:0] m, input logic h);
    return {1'b0, r, m, h, 1'b1};
  endfunction : sysv

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
      input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // One-cycle write strobe, master side
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic hold(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : hold

  task automatic flip();
    cur = ~cur;
    @(posedge ref_clk);
    raw_lapo <= cur;
  endtask : flip

  // Bounded wait for the committed state to follow the candidate
  task automatic wait_state(output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
    end while (orient_state.lapo !== cur && c < 9000);
    if (c >= 9000) begin
      err_count++;
      conclude();
    end
  endtask : wait_state

  task automatic in_range(input int v, input int lo, input int hi,
      input string msg);
    chk({7'h00, (v >= lo && v <= hi)}, 8'h01, msg);
  endtask : in_range

  task automatic t_reset();
    rd(ADDR_COUNT, rv);
    chk(rv, 8'h00, "count reset");
    rd(ADDR_BFZ, rv);
    chk(rv, 8'h84, "angle reset");
    rd(ADDR_CFG, rv);
    chk(rv, 8'h80, "cfg reset");
    rd(8'h3c, rv);
    chk(rv, 8'h00, "unmapped read");
    chk({7'h00, irq}, 8'h00, "irq after reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_count_rw();
    wr(ADDR_COUNT, 8'hff);
    rd(ADDR_COUNT, rv);
    chk(rv, 8'hff, "count all ones");
    wr(ADDR_COUNT, 8'h5a);
    rd(ADDR_COUNT, rv);
    chk(rv, 8'h5a, "count pattern");
    $display("test count_rw done");
  endtask : t_count_rw

  // Count 7 needs 8 differing ticks, so the step is measurable
  task automatic t_steps();
    wr(ADDR_COUNT, 8'h07);
    for (int i = 0; i < 11; i++) begin
      wr(ADDR_SYS, sysv(rt[i], md[i], hy[i]));
      flip();
      wait_state(n);
      in_range(n, 7 * SU * un[i], 8 * SU * un[i] + 2, "step");
    end
    $display("test steps done");
  endtask : t_steps

  task automatic t_extremes();
    wr(ADDR_SYS, sysv(3'h0, 2'h0, 1'b0));
    wr(ADDR_COUNT, 8'hff);
    flip();
    wait_state(n);
    in_range(n, 255 * SU, 256 * SU + 2, "full scale");
    wr(ADDR_COUNT, 8'h00);
    flip();
    wait_state(n);
    in_range(n, 1, SU + 2, "zero count");
    $display("test extremes done");
  endtask : t_extremes

  // A partial count must be lost when the rate or activity changes
  task automatic clr_case(input logic [7:0] d1, input logic [7:0] d2,
      input int t);
    wr(ADDR_SYS, sysv(3'h0, 2'h0, 1'b0));
    wr(ADDR_COUNT, 8'h07);
    flip();
    hold(20);
    wr(ADDR_SYS, d1);
    wr(ADDR_SYS, d2);
    wait_state(n);
    in_range(n, 7 * t - 4, 8 * t + 6, "cleared count");
  endtask : clr_case

  task automatic t_clear();
    clr_case(sysv(3'h1, 2'h0, 1'b0), sysv(3'h1, 2'h0, 1'b0), 2 * SU);
    clr_case(8'h00, sysv(3'h0, 2'h0, 1'b0), SU);
    $display("test clear done");
  endtask : t_clear

  // Decrement mode keeps part of the count across a short relapse
  task automatic t_decrement();
    wr(ADDR_CFG, 8'h40);
    rd(ADDR_CFG, rv);
    chk(rv, 8'h40, "cfg decrement mode");
    wr(ADDR_COUNT, 8'h07);
    flip();
    hold(5 * SU);
    flip();
    hold(2 * SU);
    flip();
    wait_state(n);
    in_range(n, 2 * SU, 6 * SU + 2, "decrement mode");
    wr(ADDR_CFG, 8'hc0);
    $display("test decrement done");
  endtask : t_decrement

  task automatic t_bafro();
    logic [8:0] s;
    wr(ADDR_SYS, sysv(3'h0, 2'h0, 1'b0));
    wr(ADDR_COUNT, 8'h00);
    for (int k = 0; k < 4; k++) begin
      s = 9'(5 * k);
      wr(ADDR_BFZ, {2'(k), 3'h0, 3'h4});
      z_angle_deg <= 9'd100 + s;
      hold(3 * SU);
      chk({7'h00, orient_state.bafro}, 8'h00, "front at edge");
      z_angle_deg <= 9'd101 + s;
      hold(3 * SU);
      chk({7'h00, orient_state.bafro}, 8'h01, "to back");
      z_angle_deg <= 9'd80 - s;
      hold(3 * SU);
      chk({7'h00, orient_state.bafro}, 8'h01, "back at edge");
      z_angle_deg <= 9'd79 - s;
      hold(3 * SU);
      chk({7'h00, orient_state.bafro}, 8'h00, "to front");
    end
    z_angle_deg <= 9'd0;
    $display("test bafro done");
  endtask : t_bafro

  task automatic t_lockout();
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_BFZ, {2'h2, 3'h0, 3'(k)});
      z_tilt_deci <= th[k];
      hold(3 * SU);
      chk({7'h00, z_tilt_locked_flag}, 8'h00, "at threshold");
      z_tilt_deci <= th[k] - 10'd1;
      hold(3 * SU);
      chk({7'h00, z_tilt_locked_flag}, 8'h01, "below threshold");
      chk({7'h00, orient_state.lockout}, 8'h01, "state lockout");
      z_tilt_deci <= 10'd900;
      hold(3 * SU);
      chk({7'h00, z_tilt_locked_flag}, 8'h00, "released");
    end
    $display("test lockout done");
  endtask : t_lockout

  task automatic t_irq();
    wr(ADDR_INT_MASK, 8'h00);
    rd(ADDR_INT_STATUS, rv);
    chk(rv, 8'h03, "sticky events");
    rd(ADDR_STATUS, rv);
    flip();
    wait_state(n);
    hold(1);
    chk({7'h00, irq}, 8'h00, "masked irq");
    rd(ADDR_STATUS, rv);
    chk(rv, {1'b1, 4'h0, cur, 1'b0}, "status new");
    rd(ADDR_STATUS, rv);
    chk(rv, {1'b0, 4'h0, cur, 1'b0}, "status cleared");
    wr(ADDR_INT_MASK, 8'h01);
    hold(1);
    chk({7'h00, irq}, 8'h01, "irq raised");
    rd(ADDR_INT_STATUS, rv);
    chk(rv, 8'h01, "int status");
    hold(1);
    chk({7'h00, irq}, 8'h00, "irq cleared");
    $display("test irq done");
  endtask : t_irq

  // Main sequence
  initial begin
    err_count = 0;
    n_checks = 0;
    cur = 2'h0;
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    raw_lapo = 2'h0;
    z_angle_deg = 9'd0;
    z_tilt_deci = 10'd900;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_count_rw();
    wr(ADDR_CFG, 8'hc0);
    t_steps();
    t_extremes();
    t_clear();
    t_decrement();
    t_bafro();
    t_lockout();
    t_irq();
    conclude();
  end

endmodule : odc_orient_debounce_test

// *** odc_pkg.sv ***
// Shared constants and types for the orientation debounce block
package odc_pkg;

  // Clock and debounce time base
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned STEP_UNIT_NS = 1250000;
  localparam int unsigned STEP_UNIT_CYC =
    (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CFG = 8'h11;
  localparam logic [7:0] ADDR_COUNT = 8'h12;
  localparam logic [7:0] ADDR_BFZ = 8'h13;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h20;
  localparam logic [7:0] ADDR_INT_MASK = 8'h21;
  localparam logic [7:0] ADDR_SYS = 8'h22;

  // Field positions
  localparam int CFG_CNTM_BIT = 7;
  localparam int CFG_EN_BIT = 6;
  localparam int BFZ_BKFR_LSB = 6;
  localparam int ST_NEW_BIT = 7;
  localparam int ST_LOCK_BIT = 6;
  localparam int ST_LAPO_LSB = 1;
  localparam int ST_BAFRO_BIT = 0;
  localparam int INT_ORIENT_BIT = 0;
  localparam int INT_LOCK_BIT = 1;

  // Reset values
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic CNTM_RST = 1'b1;
  localparam logic [1:0] BKFR_RST = 2'h2;
  localparam logic [2:0] ZLOCK_RST = 3'h4;
  localparam logic [1:0] INT_RST = 2'h0;

  // Step length in 1.25 ms units
  localparam logic [2:0] RATE_12HZ = 3'h5;
  localparam logic [8:0] MULT_NORMAL_SLOW = 9'h010;
  localparam logic [8:0] MULT_LNLP_SLOW = 9'h040;
  localparam logic [8:0] MULT_LP_12HZ = 9'h040;
  localparam logic [8:0] MULT_LP_SLOW = 9'h080;
  localparam logic [8:0] MULT_HIRES = 9'h002;

  // Back/front trip angles in degrees, shifted by 5 per code step
  localparam logic [8:0] BF_TO_BACK_LO = 9'h064;
  localparam logic [8:0] BF_TO_BACK_HI = 9'h104;
  localparam logic [8:0] BF_TO_FRONT_LO = 9'h050;
  localparam logic [8:0] BF_TO_FRONT_HI = 9'h118;
  localparam logic [8:0] BF_STEP_DEG = 9'h005;

  // Z-tilt lockout angles in tenths of a degree, indexed by code
  localparam logic [7:0][9:0] ZLOCK_DECI = {
    10'h194, 10'h169, 10'h140, 10'h119,
    10'h0f4, 10'h0cf, 10'h0ab, 10'h088};

  typedef enum logic [1:0] {
    MODE_NORMAL, MODE_LOW_NOISE_LOW_POWER, MODE_HIRES, MODE_LOW_POWER
  } odc_mode_t;

  typedef struct packed {
    logic lockout;
    logic [1:0] lapo;
    logic bafro;
  } odc_orient_t;

  typedef struct packed {
    logic [2:0] output_sample_rate;
    odc_mode_t mode;
    logic hybrid;
    logic active;
  } odc_sys_t;

endpackage : odc_pkg

// *** odc_step_timer.sv ***
// Debounce step tick generator driven by sample rate and power mode
`timescale 1ns/100ps
module odc_step_timer #(
  parameter int unsigned STEP_UNIT_CYCLES = odc_pkg::STEP_UNIT_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic clear,
  input odc_pkg::odc_sys_t sys,
  // Result
  output logic [8:0] step_units,
  output logic step_tick
);
  import odc_pkg::*;

  localparam int UW = $clog2(STEP_UNIT_CYCLES + 1);
  localparam logic [UW-1:0] UNIT_LAST = UW'(STEP_UNIT_CYCLES - 1);

  logic [UW-1:0] unit_reg;
  logic [8:0] mult_reg;
  logic [8:0] base_units;
  logic unit_done;

  // Step per rate and mode, in 1.25 ms units
  always_comb begin
    if (sys.mode == MODE_HIRES) begin
      base_units = (sys.output_sample_rate == 3'h0) ? 9'h001 : MULT_HIRES; // RQ7
    end else if (sys.output_sample_rate < RATE_12HZ) begin
      base_units = 9'h001 << sys.output_sample_rate; // RQ5
    end else begin
      unique case (sys.mode)
        MODE_LOW_NOISE_LOW_POWER: base_units = MULT_LNLP_SLOW; // RQ6
        MODE_LOW_POWER: base_units = (sys.output_sample_rate == RATE_12HZ) ?
          MULT_LP_12HZ : MULT_LP_SLOW; // RQ6
        default: base_units = MULT_NORMAL_SLOW; // RQ6
      endcase
    end
  end

  // Interleaved sensors halve the effective rate
  assign step_units = sys.hybrid ? (base_units << 1) : base_units; // RQ4

  assign unit_done = (unit_reg == UNIT_LAST);
  // Compare with >= so a mode change mid-step cannot overrun
  assign step_tick = unit_done && (mult_reg >= step_units - 9'h001); // RQ2

  // Base 1.25 ms divider
  always_ff @(posedge ref_clk) begin
    if (reset || clear || unit_done) begin
      unit_reg <= '0;
    end else begin
      unit_reg <= unit_reg + UW'(1);
    end
  end

  // Unit count within one step
  always_ff @(posedge ref_clk) begin
    if (reset || clear || step_tick) begin
      mult_reg <= 9'h000;
    end else if (unit_done) begin
      mult_reg <= mult_reg + 9'h001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_units_normal;
    (sys.mode == MODE_NORMAL || sys.mode == MODE_LOW_POWER) &&
      !sys.hybrid && sys.output_sample_rate == 3'h4
      |-> step_units == 9'h010;
  endproperty
  a_units_normal: assert property (p_units_normal) // RQ5
    else $error("50 Hz step is not 20 ms");
  property p_units_hires;
    sys.mode == MODE_HIRES && !sys.hybrid && sys.output_sample_rate != 3'h0
      |-> step_units == 9'h002;
  endproperty
  a_units_hires: assert property (p_units_hires) // RQ7
    else $error("high resolution step is not 2.5 ms");
  property p_units_hybrid;
    sys.hybrid && sys.mode == MODE_NORMAL && sys.output_sample_rate == 3'h1
      |-> step_units == 9'h004;
  endproperty
  a_units_hybrid: assert property (p_units_hybrid) // RQ4
    else $error("hybrid step not doubled");
  property p_units_lp_slow;
    sys.mode == MODE_LOW_POWER && !sys.hybrid && sys.output_sample_rate > 3'h5
      |-> step_units == 9'h080;
  endproperty
  a_units_lp_slow: assert property (p_units_lp_slow) // RQ6
    else $error("low power slow step is not 160 ms");

endmodule : odc_step_timer
